// ===== verilog/led_matrix_params.svh
// Purpose: constants for the matrix display control block
// Assumes: 100 MHz clock, byte-wide register port
// Notes: every offset, field position, reset value and count
`ifndef LED_MATRIX_PARAMS_SVH
`define LED_MATRIX_PARAMS_SVH

// Command addresses
`define REG_CONFIG 7'h04
`define REG_FONT 7'h05
`define REG_LAST 7'h7f
`define DIGIT_P0_BASE 7'h20
`define DIGIT_P1_BASE 7'h40
`define DIGIT_BOTH_BASE 7'h60
`define DIGIT_GROUP_MASK 7'h7c
`define CMD_ADDR_RESET 7'h00

// Configuration fields
`define CFG_NORMAL_BIT 0
`define CFG_FAST_BIT 2
`define CFG_BLINK_EN_BIT 3
`define CFG_RESYNC_BIT 4
`define CFG_CLEAR_BIT 5
`define CFG_PHASE_BIT 7

// Reset and clear values
`define DIGIT_RESET 8'h20
`define DIGIT_CLEARED 8'h00
`define FONT_PTR_RESET 8'h80
`define FONT_PTR_LAST 8'hf7
`define FONT_PTR_INVALID 8'hf8

// Font geometry
`define NUM_DIGITS 4
`define FONT_ENTRIES 120
`define GLYPH_COLUMNS 3'h5
`define USER_GLYPHS 5'h18

// Blink timing
`define CLOCK_KHZ 100000
`define SLOW_PHASE_MS 1000
`define FAST_PHASE_MS 500
`define SLOW_PHASE_CYCLES (`SLOW_PHASE_MS * `CLOCK_KHZ)
`define FAST_PHASE_CYCLES (`FAST_PHASE_MS * `CLOCK_KHZ)

`endif

// ===== verilog/led_matrix_pkg.sv
// Purpose: shared types of the matrix display control block
// Assumes: nothing
// Notes: constants live in led_matrix_params.svh
`include "led_matrix_params.svh"
package led_matrix_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [6:0] column_t;
  typedef logic [`NUM_DIGITS-1:0][7:0] digit_plane_t;
endpackage

// ===== verilog/glyph_if.sv
// Purpose: carries one digit's glyph lookup between modules
// Assumes: combinational lookup
// Notes: owner supplies code, column and memory data
`timescale 1ns/1ns
interface glyph_if;
  logic [7:0] code;
  logic [2:0] column;
  logic [6:0] ram_index;
  logic from_ram;
  logic [6:0] ram_column;
  logic [6:0] rom_column;
  logic [6:0] dots;
  modport renderer (
    input code,
    input column,
    input ram_column,
    input rom_column,
    output ram_index,
    output from_ram,
    output dots
  );
  modport owner (
    output code,
    output column,
    output ram_column,
    output rom_column,
    input ram_index,
    input from_ram,
    input dots
  );
endinterface

// ===== verilog/glyph_render.sv
// Purpose: turns a character code and column into dot data
// Assumes: column counts 0 to 4, others show blank
// Notes: purely combinational
`timescale 1ns/1ns
`include "led_matrix_params.svh"
module glyph_render (
  glyph_if.renderer g
);
  logic user_code;
  logic column_ok;
  logic [6:0] raw;
  logic [6:0] base;

  assign user_code = (g.code[6:5] == 2'b00) && (g.code[4:0] < `USER_GLYPHS); // [R12]
  assign column_ok = g.column < `GLYPH_COLUMNS;
  // Five entries per user glyph
  assign base = {g.code[4:0], 2'b00} + {2'b00, g.code[4:0]}; // [R13]
  assign g.ram_index = (user_code && column_ok) ? base + {4'h0, g.column} : 7'h00;
  assign g.from_ram = user_code;
  assign raw = user_code ? g.ram_column : g.rom_column; // [R10]
  assign g.dots = !column_ok ? 7'h00 : (g.code[7] ? ~raw : raw); // [R11]
endmodule

// ===== verilog/led_matrix_config_and_font_ram.sv
// Purpose: configuration byte, digit planes, blink timing, user font memory
// Assumes: bus engine delivers command and data bytes at their acknowledge
// Notes: ROM glyph columns come from outside, per digit
//
// Summary of operation
// [R1] Config bit 0 clear means shutdown, set means normal operation.
// [R2] Config bit 2 picks one second or half second per blink phase.
// [R3] Config bit 3 set drives display from both digit planes.
// [R4] Blink disabled: only first plane drives display, second ignored.
// [R5] Blink on: first plane in first half, second plane in second half.
// [R6] Writing config bit 4 as one resets blink timing counters.
// [R7] That same resync also restarts the multiplex sequence.
// [R8] Writing config bit 5 as one clears every digit in both planes.
// [R9] Config read bit 7 shows blink phase, one during first plane.
// [R10] Lower seven bits of a digit value select one of 128 characters.
// [R11] Digit value top bit set shows the glyph with dots inverted.
// [R12] Codes 0 to 23 use user glyphs, the rest use fixed glyphs.
// [R13] User font memory holds 120 seven-bit columns, five per glyph.
// [R14] Font register read returns entry at pointer, top bit clear, then advances.
// [R15] Font write with top bit set loads pointer, otherwise stores and advances.
// [R16] Font pointer never reads back; font register reads give data.
// [R17] Pointer 0x80 to 0xF6 advances by one per font access.
// [R18] Font access at pointer 0xF7 wraps pointer to 0x80.
// [R19] Pointer writes of 0xF8 to 0xFF load 0x80 instead.
// [R20] Unused font entries act as seven-bit scratch storage.
// [R21] Command address holds at font register while pointer alone advances.
// [R22] Font pointer starts at 0x80 after reset.
// [R23] Config bits 6 and 1 ignore writes and read as zero.
`timescale 1ns/1ns
`include "led_matrix_params.svh"
module led_matrix_config_and_font_ram #(
  parameter int slow_phase_cycles = `SLOW_PHASE_CYCLES,
  parameter int fast_phase_cycles = `FAST_PHASE_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  input wire logic rd_valid,
  output logic [7:0] rd_data,
  output logic rd_ready,
  input wire logic [2:0] scan_column,
  input wire logic [`NUM_DIGITS-1:0][6:0] rom_column,
  output logic shutdown,
  output logic blink_phase,
  output logic scan_restart,
  output logic [`NUM_DIGITS-1:0][6:0] glyph_code,
  output logic [`NUM_DIGITS-1:0] glyph_from_ram,
  output logic [`NUM_DIGITS-1:0][6:0] glyph_dots
);

  ////////////////////////////////////////////////////////////////////////////
  // Command address

  logic [6:0] cmd_addr;
  logic [6:0] next_cmd_addr;
  logic data_access;
  logic addr_holds;

  assign data_access = wr_valid | rd_valid;
  // Font and last address hold so bursts stay put
  assign addr_holds = (cmd_addr == `REG_FONT) || (cmd_addr == `REG_LAST);

  always_comb begin
    next_cmd_addr = cmd_addr;
    if (cmd_valid) begin
      next_cmd_addr = cmd_byte[6:0];
    end else if (data_access && !addr_holds) begin
      next_cmd_addr = cmd_addr + 7'h01;
    end
  end // [R21]

  always_ff @(posedge clock) begin
    if (reset) begin
      cmd_addr <= `CMD_ADDR_RESET;
    end else begin
      cmd_addr <= next_cmd_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access decode

  logic wr_config;
  logic wr_font;
  logic rd_font;
  logic font_ptr_load;
  logic font_data_wr;
  logic font_step;
  logic wr_p0;
  logic wr_p1;
  logic wr_both;
  logic [1:0] digit_sel;
  logic resync;
  logic clear_all;
  logic [6:0] digit_group;

  assign wr_config = wr_valid && (cmd_addr == `REG_CONFIG);
  assign wr_font = wr_valid && (cmd_addr == `REG_FONT);
  assign rd_font = rd_valid && (cmd_addr == `REG_FONT);
  assign font_ptr_load = wr_font && wr_data[7]; // [R15]
  assign font_data_wr = wr_font && !wr_data[7]; // [R15]
  assign font_step = font_data_wr || rd_font;
  // Low two address bits pick the digit within a group
  assign digit_group = cmd_addr & `DIGIT_GROUP_MASK;
  assign wr_p0 = wr_valid && (digit_group == `DIGIT_P0_BASE);
  assign wr_p1 = wr_valid && (digit_group == `DIGIT_P1_BASE);
  assign wr_both = wr_valid && (digit_group == `DIGIT_BOTH_BASE);
  assign digit_sel = cmd_addr[1:0];
  assign resync = wr_config && wr_data[`CFG_RESYNC_BIT]; // [R6]
  assign clear_all = wr_config && wr_data[`CFG_CLEAR_BIT]; // [R8]

  ////////////////////////////////////////////////////////////////////////////
  // Configuration byte

  logic cfg_normal;
  logic cfg_fast;
  logic cfg_blink_en;

  // Bits 1 and 6 have no storage
  always_ff @(posedge clock) begin
    if (reset) begin
      cfg_normal <= 1'b0;
      cfg_fast <= 1'b0;
      cfg_blink_en <= 1'b0;
    end else if (wr_config) begin
      cfg_normal <= wr_data[`CFG_NORMAL_BIT]; // [R1]
      cfg_fast <= wr_data[`CFG_FAST_BIT]; // [R2]
      cfg_blink_en <= wr_data[`CFG_BLINK_EN_BIT]; // [R3]
    end
  end // [R23]

  assign shutdown = !cfg_normal; // [R1]

  ////////////////////////////////////////////////////////////////////////////
  // Blink timing

  logic [31:0] blink_count;
  logic [31:0] phase_last;
  logic [31:0] next_blink_count;
  logic next_blink_phase;
  logic phase_end;

  assign phase_last = cfg_fast ? fast_phase_cycles - 32'h1 : slow_phase_cycles - 32'h1; // [R2]

  assign phase_end = blink_count >= phase_last;

  always_comb begin
    next_blink_count = blink_count + 32'h1;
    next_blink_phase = blink_phase;
    if (resync) begin
      // Counter and phase both restart at the acknowledge
      next_blink_count = 32'h0;
      next_blink_phase = 1'b1;
    end else if (phase_end) begin
      next_blink_count = 32'h0;
      next_blink_phase = !blink_phase;
    end
  end // [R6]

  // Keeps running in shutdown and with blink off
  always_ff @(posedge clock) begin
    if (reset) begin
      blink_count <= 32'h0;
      blink_phase <= 1'b1;
    end else begin
      blink_count <= next_blink_count;
      blink_phase <= next_blink_phase;
    end
  end

  // Tells the scan logic to start its sequence over
  always_ff @(posedge clock) begin
    if (reset) begin
      scan_restart <= 1'b0;
    end else begin
      scan_restart <= resync; // [R7]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Digit planes

  led_matrix_pkg::digit_plane_t plane0;
  led_matrix_pkg::digit_plane_t plane1;

  // First plane
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < `NUM_DIGITS; i++) begin
        plane0[i] <= `DIGIT_RESET;
      end
    end else if (clear_all) begin
      for (int i = 0; i < `NUM_DIGITS; i++) begin
        plane0[i] <= `DIGIT_CLEARED;
      end // [R8]
    end else if (wr_p0 || wr_both) begin
      plane0[digit_sel] <= wr_data;
    end
  end

  // Second plane
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < `NUM_DIGITS; i++) begin
        plane1[i] <= `DIGIT_RESET;
      end
    end else if (clear_all) begin
      for (int i = 0; i < `NUM_DIGITS; i++) begin
        plane1[i] <= `DIGIT_CLEARED;
      end // [R8]
    end else if (wr_p1 || wr_both) begin
      plane1[digit_sel] <= wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // User font memory and pointer

  logic [6:0] font_ram [0:`FONT_ENTRIES-1];
  logic [7:0] font_ptr;
  logic [7:0] next_font_ptr;
  logic [6:0] font_slot;

  // Pointer range 0x80..0xF7 maps onto slots 0..119
  assign font_slot = font_ptr[6:0];
  assign next_font_ptr = (font_ptr == `FONT_PTR_LAST) ? `FONT_PTR_RESET // [R18]
                                                      : font_ptr + 8'h01; // [R17]

  // Out-of-range pointer writes fall back to the first entry
  always_ff @(posedge clock) begin
    if (reset) begin
      font_ptr <= `FONT_PTR_RESET; // [R22]
    end else if (font_ptr_load) begin
      font_ptr <= (wr_data >= `FONT_PTR_INVALID) ? `FONT_PTR_RESET : wr_data; // [R19]
    end else if (font_step) begin
      font_ptr <= next_font_ptr; // [R14]
    end
  end

  // Only seven bits kept per entry, any slot usable as scratch
  always_ff @(posedge clock) begin
    if (font_data_wr) begin
      font_ram[font_slot] <= wr_data[6:0]; // [R20]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read

  led_matrix_pkg::byte_t read_mux;

  always_comb begin
    read_mux = 8'h00;
    case (cmd_addr)
      `REG_CONFIG: begin
        read_mux = {blink_phase, 3'h0, cfg_blink_en, cfg_fast, 1'b0, cfg_normal}; // [R9]
      end
      `REG_FONT: begin
        read_mux = {1'b0, font_ram[font_slot]}; // [R16]
      end
      default: begin
        case (digit_group)
          `DIGIT_P0_BASE: begin
            read_mux = plane0[digit_sel];
          end
          `DIGIT_P1_BASE: begin
            read_mux = plane1[digit_sel];
          end
          // Both-plane writes and unused addresses read as zero
          default: begin
            read_mux = 8'h00;
          end
        endcase
      end
    endcase
  end

  // Answer strobe, one cycle after the request
  always_ff @(posedge clock) begin
    if (reset) begin
      rd_ready <= 1'b0;
    end else begin
      rd_ready <= rd_valid;
    end
  end

  // Read data holds until the next request
  always_ff @(posedge clock) begin
    if (reset) begin
      rd_data <= 8'h00;
    end else if (rd_valid) begin
      rd_data <= read_mux; // [R14]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plane selection and glyph rendering

  led_matrix_pkg::digit_plane_t shown_code;
  logic show_second;

  // Second plane only in the second half and only with blink on
  assign show_second = cfg_blink_en && !blink_phase; // [R5]

  glyph_if glyph [`NUM_DIGITS] ();

  for (genvar d = 0; d < `NUM_DIGITS; d++) begin : g_digit
    assign shown_code[d] = show_second ? plane1[d] : plane0[d]; // [R4]
    assign glyph[d].code = shown_code[d];
    assign glyph[d].column = scan_column;
    assign glyph[d].ram_column = font_ram[glyph[d].ram_index];
    assign glyph[d].rom_column = rom_column[d];

    glyph_render u_render (
      .g(glyph[d])
    );

    always_ff @(posedge clock) begin
      if (reset) begin
        glyph_code[d] <= 7'h00;
      end else begin
        glyph_code[d] <= shown_code[d][6:0]; // [R10]
      end
    end

    always_ff @(posedge clock) begin
      if (reset) begin
        glyph_from_ram[d] <= 1'b0;
      end else begin
        glyph_from_ram[d] <= glyph[d].from_ram; // [R12]
      end
    end

    // Shutdown blanks every dot but keeps the codes
    always_ff @(posedge clock) begin
      if (reset) begin
        glyph_dots[d] <= 7'h00;
      end else begin
        glyph_dots[d] <= shutdown ? 7'h00 : glyph[d].dots; // [R11]
      end
    end
  end

endmodule

// ===== sim/led_matrix_properties.sv
// Purpose: port checks of the display control block
// Assumes: one clock, synchronous reset
// Notes: follows the command address itself
`timescale 1ns/1ns
module led_matrix_properties (
  input wire logic clock,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic rd_ready,
  input wire logic shutdown,
  input wire logic blink_phase,
  input wire logic scan_restart,
  input wire logic [3:0][6:0] glyph_dots
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  logic at_cfg;
  logic at_font;
  logic [7:0] low_cnt;
  ////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (reset) begin
      at_cfg <= 1'b0;
    end else if (cmd_valid) begin
      at_cfg <= cmd_byte[6:0] == 7'h04;
    end else if (wr_valid | rd_valid) begin
      at_cfg <= 1'b0;
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      at_font <= 1'b0;
    end else if (cmd_valid) begin
      at_font <= cmd_byte[6:0] == 7'h05;
    end else if ((wr_valid | rd_valid) && at_cfg) begin
      at_font <= 1'b1;
    end
  end
  ////////////////////////////////////////
  // Counts cycles of the second phase, saturating
  always_ff @(posedge clock) begin
    if (reset || blink_phase) begin
      low_cnt <= 8'h00;
    end else if (low_cnt != 8'hff) begin
      low_cnt <= low_cnt + 8'h01;
    end
  end
  sequence resync_write;
    at_cfg && wr_valid && wr_data[4];
  endsequence
  sequence restart_seen;
    scan_restart && blink_phase ##1 !scan_restart;
  endsequence
  a_resync_restart: assert property (resync_write |=> restart_seen)
    else $error("no restart after resync");
  a_no_restart: assert property (at_cfg && wr_valid && !wr_data[4] |=> !scan_restart)
    else $error("restart without resync");
  a_shutdown_bit: assert property (at_cfg && wr_valid |=> shutdown == !$past(wr_data[0]))
    else $error("shutdown not from config bit");
  a_ready_next: assert property (rd_valid |=> rd_ready)
    else $error("read not answered");
  a_ready_cause: assert property (rd_ready |-> $past(rd_valid))
    else $error("answer without read");
  a_phase_readback: assert property (at_cfg && rd_valid |=>
    rd_data[7] == $past(blink_phase) && rd_data[6:4] == 3'h0 && !rd_data[1])
    else $error("config read wrong");
  a_font_msb: assert property (at_font && rd_valid |=> !rd_data[7])
    else $error("font read top bit set");
  a_phase_dwell: assert property ($rose(blink_phase) && !scan_restart |-> low_cnt >= 8'd8)
    else $error("second phase too short");
  a_blank_dots: assert property (shutdown |=> glyph_dots == '0)
    else $error("dots lit in shutdown");
endmodule

// ===== sim/host_model.sv
// Purpose: host side of the register port
// Assumes: one byte a call, changes at falling edge
// Notes: idle lines show the inverse of the last byte
`timescale 1ns/1ns
module host_model (
  input wire logic clock,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic wr_valid,
  output logic [7:0] wr_data,
  output logic rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic rd_ready
);
  initial begin
    cmd_valid = 1'b0;
    wr_valid = 1'b0;
    rd_valid = 1'b0;
    cmd_byte = 8'h00;
    wr_data = 8'h00;
  end
  task automatic send_cmd(input logic [7:0] a);
    @(negedge clock);
    cmd_byte = a;
    cmd_valid = 1'b1;
    @(negedge clock);
    cmd_valid = 1'b0;
    cmd_byte = ~a;
  endtask
  // At the font register, top bit set loads the pointer, clear stores data
  task automatic send_data(input logic [7:0] d);
    @(negedge clock);
    wr_data = d;
    wr_valid = 1'b1;
    @(negedge clock);
    wr_valid = 1'b0;
    wr_data = ~d;
  endtask
  task automatic fetch(output logic [7:0] d);
    @(negedge clock);
    rd_valid = 1'b1;
    @(negedge clock);
    rd_valid = 1'b0;
    d = rd_ready ? rd_data : 8'hxx;
  endtask
endmodule

// ===== sim/tb.sv
// Purpose: self-checking bench of the display control block
// Assumes: short blink phases of 20 and 10 cycles
// Notes: unwritten font entries are never read
`timescale 1ns/1ns
module tb;
  logic clock;
  logic reset;
  logic cmd_valid;
  logic [7:0] cmd_byte;
  logic wr_valid;
  logic [7:0] wr_data;
  logic rd_valid;
  logic [7:0] rd_data;
  logic rd_ready;
  logic [2:0] scan_column;
  logic [3:0][6:0] rom_column;
  logic shutdown;
  logic blink_phase;
  logic scan_restart;
  logic [3:0][6:0] glyph_code;
  logic [3:0] glyph_from_ram;
  logic [3:0][6:0] glyph_dots;
  int error_cnt;
  int samples_checked;
  led_matrix_config_and_font_ram #(.slow_phase_cycles(20), .fast_phase_cycles(10))
    led_matrix_config_and_font_ram_inst (.clock, .reset, .cmd_valid, .cmd_byte,
    .wr_valid, .wr_data, .rd_valid, .rd_data, .rd_ready, .scan_column, .rom_column,
    .shutdown, .blink_phase, .scan_restart, .glyph_code, .glyph_from_ram, .glyph_dots);
  host_model host_model_inst (.clock, .cmd_valid, .cmd_byte, .wr_valid, .wr_data,
    .rd_valid, .rd_data, .rd_ready);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  ////////////////////////////////////////
  task give_verdict;
    $display("checked %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wreg(input logic [7:0] a, input logic [7:0] d);
    host_model_inst.send_cmd(a);
    host_model_inst.send_data(d);
  endtask
  task rreg(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host_model_inst.send_cmd(a);
    host_model_inst.fetch(v);
    chk(v, exp);
  endtask
  task wait_phase(input logic lvl, output int n);
    n = 0;
    while (blink_phase !== lvl && n < 100) begin
      @(negedge clock);
      n++;
    end
    if (n == 100) begin
      error_cnt++;
      $display("BAD %0t blink phase never changed", $time);
      give_verdict;
    end
  endtask
  ////////////////////////////////////////
  task t_reset;
    rreg(8'h04, 8'h80);
    chk({7'h0, shutdown}, 8'h01);
    wreg(8'h05, 8'h55);
    wreg(8'h05, 8'h80);
    rreg(8'h05, 8'h55);
    $display("reset test done");
  endtask
  task t_font;
    wreg(8'h05, 8'hf6);
    host_model_inst.send_data(8'h11);
    host_model_inst.send_data(8'h22);
    host_model_inst.send_data(8'h7f);
    wreg(8'h05, 8'hff);
    rreg(8'h05, 8'h7f);
    wreg(8'h05, 8'hf6);
    rreg(8'h05, 8'h11);
    rreg(8'h05, 8'h22);
    rreg(8'h05, 8'h7f);
    $display("font test done");
  endtask
  task t_glyph;
    logic [7:0] cd;
    cd = 8'h0f;
    wreg(8'h05, 8'h99);
    repeat (5) begin
      host_model_inst.send_data(cd);
      cd = cd + 8'h11;
    end
    wreg(8'h04, 8'h01);
    wreg(8'h20, 8'h85);
    host_model_inst.send_data(8'h17);
    host_model_inst.send_data(8'h18);
    host_model_inst.send_data(8'h7f);
    @(negedge clock);
    chk({1'b0, glyph_code[0]}, 8'h05);
    chk({1'b0, glyph_code[3]}, 8'h7f);
    chk({4'h0, glyph_from_ram}, 8'h03);
    chk({1'b0, glyph_dots[0]}, 8'h70);
    chk({1'b0, glyph_dots[2]}, 8'h2a);
    cd = 8'h0f;
    for (int c = 0; c < 5; c++) begin
      scan_column = c[2:0];
      rom_column[3] = cd[6:0] ^ 7'h55;
      @(negedge clock);
      chk({1'b0, glyph_dots[0]}, {1'b0, ~cd[6:0]});
      chk({1'b0, glyph_dots[3]}, {1'b0, cd[6:0] ^ 7'h55});
      cd = cd + 8'h11;
    end
    scan_column = 3'h5;
    @(negedge clock);
    chk({1'b0, glyph_dots[2]}, 8'h00);
    scan_column = 3'h0;
    $display("glyph test done");
  endtask
  task t_clear;
    wreg(8'h60, 8'h33);
    rreg(8'h20, 8'h33);
    rreg(8'h40, 8'h33);
    rreg(8'h60, 8'h00);
    rreg(8'h10, 8'h00);
    wreg(8'h04, 8'h21);
    rreg(8'h20, 8'h00);
    rreg(8'h43, 8'h00);
    $display("clear test done");
  endtask
  task t_config;
    logic [7:0] v;
    wreg(8'h04, 8'hcf);
    chk({7'h0, shutdown}, 8'h00);
    host_model_inst.send_cmd(8'h04);
    host_model_inst.fetch(v);
    chk(v & 8'h7f, 8'h0d);
    wreg(8'h04, 8'h00);
    chk({7'h0, shutdown}, 8'h01);
    $display("config test done");
  endtask
  task t_blink;
    int n;
    wreg(8'h20, 8'h35);
    wreg(8'h40, 8'h21);
    wreg(8'h04, 8'h19);
    wait_phase(1'b0, n);
    chk(n[7:0], 8'd20);
    @(negedge clock);
    chk({1'b0, glyph_code[0]}, 8'h21);
    wait_phase(1'b1, n);
    wreg(8'h04, 8'h1d);
    wait_phase(1'b0, n);
    chk(n[7:0], 8'd10);
    wreg(8'h04, 8'h05);
    wait_phase(1'b0, n);
    @(negedge clock);
    chk({1'b0, glyph_code[0]}, 8'h35);
    $display("blink test done");
  endtask
  task t_rerun;
    reset = 1'b1;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    rreg(8'h20, 8'h20);
    rreg(8'h04, 8'h80);
    wreg(8'h05, 8'h44);
    wreg(8'h05, 8'h80);
    rreg(8'h05, 8'h44);
    $display("second reset test done");
  endtask
  ////////////////////////////////////////
  initial begin
    reset = 1'b1;
    scan_column = 3'h0;
    rom_column = {4{7'h2a}};
    error_cnt = 0;
    samples_checked = 0;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    t_reset;
    t_font;
    t_glyph;
    t_clear;
    t_config;
    t_blink;
    t_rerun;
    give_verdict;
  end
endmodule
bind led_matrix_config_and_font_ram led_matrix_properties props_inst (.clock, .reset,
  .cmd_valid, .cmd_byte, .wr_valid, .wr_data, .rd_valid, .rd_data, .rd_ready,
  .shutdown, .blink_phase, .scan_restart, .glyph_dots);
